/* rtl/clk_ctrl_consts.svh */
// Constants for the system clock control block.
// Assumes byte addressing on a 32-bit AHB-Lite bus.
`ifndef CLK_CTRL_CONSTS_SVH
`define CLK_CTRL_CONSTS_SVH

// Register byte offsets
`define OFS_CLOCK_CONTROL  8'h00
`define OFS_CLOCK_PRESCALE 8'h04
`define OFS_FAST_TRIM      8'h08
`define OFS_TEMP_TRIM_A    8'h0C
`define OFS_TEMP_TRIM_B    8'h10
`define OFS_SLOW_TRIM      8'h14
`define OFS_CHANGE_PROTECT 8'h18

// Clock control bit positions
`define BIT_OSC_STABLE     7
`define BIT_SEL_TRIGGER    6
`define BIT_CLK_OUT_EN     5
`define BIT_STARTUP_TIME   4

// Reset values before fuses are loaded, and prescaler codes
`define RST_SOURCE_SEL     4'h2
`define RST_DIV_SEL        4'h3
`define RST_TRIM           8'h80
`define DIV_BY_ONE         4'h0
`define DIV_BY_EIGHT       4'h3
`define DIV_MAX_CODE       4'h8

// Change protection: signature value is arbitrary
`define CHANGE_SIGNATURE   8'hA5
`define WINDOW_TICKS       3'h4

// Oscillator time-out
`define STARTUP_TIME_MS    16
`define CLK_FREQ_MHZ       200

`endif

/* rtl/clk_ctrl_pkg.sv */
// Types shared by the system clock control block.
// Assumes the constants header is included by each user.
package clk_ctrl_pkg;

   typedef logic [3:0] sel_t;
   typedef logic [7:0] trim_t;

   typedef enum logic [1:0] {
      FUSE_SYNC1,
      FUSE_SYNC2,
      FUSE_LOAD,
      FUSE_RUN
   } fuse_state_e;

endpackage

/* rtl/clk_prescaler.sv */
// Power-of-two system clock prescaler producing a tick and a clock level.
// Assumes it runs on the undivided master clock.
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_consts.svh"

module clk_prescaler
   import clk_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // Requested setting
   input  wire clk_ctrl_pkg::sel_t divide_select,
   // Divided clock
   output logic                   sys_tick,
   output logic                   div_clk
);

   sel_t       active_div;
   logic [7:0] cnt;
   logic       wrap;

   // Reserved codes saturate at the largest factor
   function automatic logic [7:0] div_mask(input sel_t code);
      sel_t c;
      c = (code > `DIV_MAX_CODE) ? `DIV_MAX_CODE : code;
      div_mask = 8'(9'h1FF >> (4'h9 - c)) ;
   endfunction

   assign wrap = (cnt == div_mask(active_div));

   ////////////////////////////////////////////////////////////////////
   // New setting is taken only at a period boundary, so no period is
   // ever shorter than the old or the new one
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt        <= 8'h00;
         active_div <= `RST_DIV_SEL;
      end
      else if (wrap)
      begin
         cnt        <= 8'h00;
         active_div <= divide_select;
      end
      else
      begin
         cnt <= 8'(cnt + 8'h01);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sys_tick <= 1'b0;
         div_clk  <= 1'b0;
      end
      else
      begin
         sys_tick <= wrap;
         // High for the first half of each divided period, and always high at factor one
         div_clk  <= wrap ? 1'b1 :
                     ((8'(cnt + 8'h01) & ~(div_mask(active_div) >> 1)) == 8'h00);
      end
   end

endmodule

`default_nettype wire

/* rtl/sys_clk_ctrl.sv */
// System clock control: source selection, prescaler, trims, AHB-Lite slave.
// Assumes hclk is the undivided master clock and fuses are static pins.
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_consts.svh"

module sys_clk_ctrl
   import clk_ctrl_pkg::*;
#(
   parameter int unsigned STARTUP_CYCLES =
      `STARTUP_TIME_MS * 1000 * `CLK_FREQ_MHZ
)
(
   // Clock and reset
   input  wire logic               hclk,
   input  wire logic               hresetn,
   // AHB-Lite slave
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic [31:0]             hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   // Fuses and factory values
   input  wire clk_ctrl_pkg::sel_t  fuse_source_select,
   input  wire logic               fuse_startup_time,
   input  wire logic               clk_out_fuse,
   input  wire logic               divide_by_eight_fuse,
   input  wire clk_ctrl_pkg::trim_t factory_fast_trim,
   input  wire clk_ctrl_pkg::trim_t factory_slow_trim,
   // Oscillator interface
   input  wire logic               osc_ready,
   output clk_ctrl_pkg::sel_t      osc_enable_select,
   output clk_ctrl_pkg::sel_t      active_source,
   output logic                    startup_time_sel,
   output clk_ctrl_pkg::trim_t     fast_trim_value,
   output clk_ctrl_pkg::trim_t     fast_temp_trim_a,
   output clk_ctrl_pkg::trim_t     fast_temp_trim_b,
   output clk_ctrl_pkg::trim_t     slow_trim_value,
   // System clock
   output logic                    sys_tick,
   output logic                    sys_clk,
   output logic                    clk_out_pin,
   output logic                    clk_out_oe_n
);

   localparam int unsigned TW = $clog2(STARTUP_CYCLES + 1);

   // Fuse and oscillator synchronisers
   logic [12:0]  fuse_s1;
   logic [12:0]  fuse_s2;
   trim_t        fast_s1;
   trim_t        fast_s2;
   trim_t        slow_s1;
   trim_t        slow_s2;
   logic         rdy_s1;
   logic         rdy_s2;
   fuse_state_e  fuse_state;
   logic         loaded;

   // Registers
   sel_t         source_select;
   logic         clk_out_enable_copy;
   sel_t         divide_select;
   logic         osc_stable_flag;
   logic [TW-1:0] osc_timer;
   logic [2:0]   window;

   // Bus pipeline
   logic         dp_write;
   logic         dp_read;
   logic         rd_done;
   logic [7:0]   dp_addr;
   logic         accept;
   logic [7:0]   wbyte;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   assign loaded = (fuse_state == FUSE_RUN);
   assign accept = hsel & hready & htrans[1] & loaded;
   assign wbyte  = hwdata[7:0];
   assign hresp  = 1'b0;
   assign hreadyout = loaded & ~(dp_read & ~rd_done);

   ////////////////////////////////////////////////////////////////////
   // Fuses are caught a few cycles after reset release, never by the
   // asynchronous reset itself
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         fuse_s1 <= 13'h0000;
         fuse_s2 <= 13'h0000;
         fast_s1 <= `RST_TRIM;
         fast_s2 <= `RST_TRIM;
         slow_s1 <= `RST_TRIM;
         slow_s2 <= `RST_TRIM;
         rdy_s1  <= 1'b0;
         rdy_s2  <= 1'b0;
      end
      else
      begin
         fuse_s1 <= {fuse_source_select, fuse_startup_time, clk_out_fuse,
                     divide_by_eight_fuse, 6'h00};
         fuse_s2 <= fuse_s1;
         fast_s1 <= factory_fast_trim;
         fast_s2 <= fast_s1;
         slow_s1 <= factory_slow_trim;
         slow_s2 <= slow_s1;
         rdy_s1  <= osc_ready;
         rdy_s2  <= rdy_s1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         fuse_state <= FUSE_SYNC1;
      else
      begin
         unique case (fuse_state)
            FUSE_SYNC1: fuse_state <= FUSE_SYNC2;
            FUSE_SYNC2: fuse_state <= FUSE_LOAD;
            FUSE_LOAD:  fuse_state <= FUSE_RUN;
            FUSE_RUN:   fuse_state <= FUSE_RUN;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Bus address phase capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_write <= 1'b0;
         dp_read  <= 1'b0;
         rd_done  <= 1'b0;
         dp_addr  <= 8'h00;
      end
      else
      begin
         if (accept)
         begin
            dp_write <= hwrite;
            dp_read  <= ~hwrite;
            rd_done  <= 1'b0;
            dp_addr  <= haddr[7:0];
         end
         else if (hready)
         begin
            dp_write <= 1'b0;
            dp_read  <= dp_read & ~rd_done;
            rd_done  <= dp_read & ~rd_done;
         end
         else if (dp_read & ~rd_done)
         begin
            dp_write <= 1'b0;
            rd_done  <= 1'b1;
         end
      end
   end

   // Read data is taken in a wait state so a write just before is seen
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (dp_read & ~rd_done)
      begin
         hrdata <= 32'h0000_0000;
         if (hit(dp_addr, `OFS_CLOCK_CONTROL))
            hrdata[7:0] <= {osc_stable_flag, 1'b0, clk_out_enable_copy,
                            startup_time_sel, source_select};
         if (hit(dp_addr, `OFS_CLOCK_PRESCALE))
            hrdata[7:0] <= {4'h0, divide_select};
         if (hit(dp_addr, `OFS_FAST_TRIM))
            hrdata[7:0] <= fast_trim_value;
         if (hit(dp_addr, `OFS_TEMP_TRIM_A))
            hrdata[7:0] <= fast_temp_trim_a;
         if (hit(dp_addr, `OFS_TEMP_TRIM_B))
            hrdata[7:0] <= fast_temp_trim_b;
         if (hit(dp_addr, `OFS_SLOW_TRIM))
            hrdata[7:0] <= slow_trim_value;
         if (hit(dp_addr, `OFS_CHANGE_PROTECT))
            hrdata[7:0] <= {7'h00, (window != 3'h0)};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Protected window, counted in divided clock cycles because those
   // are the processor's instruction cycles
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         window <= 3'h0;
      else if (dp_write && hit(dp_addr, `OFS_CHANGE_PROTECT) &&
               wbyte == `CHANGE_SIGNATURE)
         window <= `WINDOW_TICKS;
      else if (dp_write && window != 3'h0 &&
               (hit(dp_addr, `OFS_CLOCK_CONTROL) ||
                hit(dp_addr, `OFS_CLOCK_PRESCALE)))
         window <= 3'h0;
      else if (sys_tick && window != 3'h0)
         window <= 3'(window - 3'h1);
   end

   ////////////////////////////////////////////////////////////////////
   // Clock source selection
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         source_select     <= `RST_SOURCE_SEL;
         osc_enable_select <= `RST_SOURCE_SEL;
         active_source     <= `RST_SOURCE_SEL;
      end
      else if (fuse_state == FUSE_LOAD)
      begin
         source_select     <= fuse_s2[12:9];
         osc_enable_select <= fuse_s2[12:9];
         active_source     <= fuse_s2[12:9];
      end
      else if (dp_write && hit(dp_addr, `OFS_CLOCK_CONTROL) &&
               window != 3'h0)
      begin
         source_select     <= wbyte[3:0];
         osc_enable_select <= wbyte[3:0];
         if (wbyte[`BIT_SEL_TRIGGER])
            active_source <= wbyte[3:0];
      end
   end

   // Bits outside the protected field are plain writes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clk_out_enable_copy <= 1'b0;
         startup_time_sel    <= 1'b0;
      end
      else if (fuse_state == FUSE_LOAD)
      begin
         clk_out_enable_copy <= fuse_s2[7];
         startup_time_sel    <= fuse_s2[8];
      end
      else if (dp_write && hit(dp_addr, `OFS_CLOCK_CONTROL))
      begin
         clk_out_enable_copy <= wbyte[`BIT_CLK_OUT_EN];
         startup_time_sel    <= wbyte[`BIT_STARTUP_TIME];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Oscillator time-out restarts whenever another oscillator is asked for
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         osc_timer       <= TW'(0);
         osc_stable_flag <= 1'b0;
      end
      else if (fuse_state != FUSE_RUN ||
               (dp_write && hit(dp_addr, `OFS_CLOCK_CONTROL) &&
                window != 3'h0 && wbyte[3:0] != osc_enable_select))
      begin
         osc_timer       <= TW'(0);
         osc_stable_flag <= 1'b0;
      end
      else
      begin
         if (osc_timer != TW'(STARTUP_CYCLES))
            osc_timer <= TW'(osc_timer + TW'(1));
         osc_stable_flag <= (osc_timer == TW'(STARTUP_CYCLES)) & rdy_s2;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Prescaler setting
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         divide_select <= `RST_DIV_SEL;
      else if (fuse_state == FUSE_LOAD)
         divide_select <= fuse_s2[6] ? `DIV_BY_EIGHT : `DIV_BY_ONE;
      else if (dp_write && hit(dp_addr, `OFS_CLOCK_PRESCALE) &&
               window != 3'h0)
         divide_select <= wbyte[3:0];
   end

   // Trim registers drive the oscillators directly
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         fast_trim_value  <= `RST_TRIM;
         fast_temp_trim_a <= `RST_TRIM;
         fast_temp_trim_b <= `RST_TRIM;
         slow_trim_value  <= `RST_TRIM;
      end
      else if (fuse_state == FUSE_LOAD)
      begin
         fast_trim_value <= fast_s2;
         slow_trim_value <= slow_s2;
      end
      else if (dp_write)
      begin
         if (hit(dp_addr, `OFS_FAST_TRIM))
            fast_trim_value <= wbyte;
         if (hit(dp_addr, `OFS_TEMP_TRIM_A))
            fast_temp_trim_a <= wbyte;
         if (hit(dp_addr, `OFS_TEMP_TRIM_B))
            fast_temp_trim_b <= wbyte;
         if (hit(dp_addr, `OFS_SLOW_TRIM))
            slow_trim_value <= wbyte;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Divided system clock
   clk_prescaler u_prescaler
   (
      .hclk          (hclk),
      .hresetn       (hresetn),
      .divide_select (divide_select),
      .sys_tick      (sys_tick),
      .div_clk       (sys_clk)
   );

   // Output pin stays quiet in reset and until fuses are in
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clk_out_pin  <= 1'b0;
         clk_out_oe_n <= 1'b1;
      end
      else
      begin
         clk_out_pin  <= clk_out_enable_copy & sys_clk;
         clk_out_oe_n <= ~clk_out_enable_copy;
      end
   end

endmodule

`default_nettype wire

/* tb/sys_clk_ctrl_props.sv */
// Checker for the system clock control block.
// Assumes hready is tied to hreadyout and sees only top-level ports.
`timescale 1ns/1ps
`default_nettype none
module sys_clk_ctrl_props
   import clk_ctrl_pkg::*;
(
   // Clock, reset and bus
   input wire logic                hclk,
   input wire logic                hresetn,
   input wire logic                hsel,
   input wire logic [31:0]         haddr,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic                hready,
   input wire logic [31:0]         hrdata,
   input wire logic                hreadyout,
   // Observed outputs
   input wire clk_ctrl_pkg::sel_t  osc_enable_select,
   input wire clk_ctrl_pkg::sel_t  active_source,
   input wire clk_ctrl_pkg::trim_t fast_trim_value,
   input wire clk_ctrl_pkg::trim_t fast_temp_trim_a,
   input wire logic                sys_clk,
   input wire logic                clk_out_pin,
   input wire logic                clk_out_oe_n
);
   logic       acc_rd;
   logic       dp_wr;
   logic [7:0] dp_addr;
   assign acc_rd = hsel && hready && htrans[1] && !hwrite && hreadyout;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////
   // Data phase tracking, held while the slave stalls
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr   <= 1'b0;
         dp_addr <= 8'h00;
      end
      else if (hready)
      begin
         dp_wr   <= hsel && htrans[1] && hwrite;
         dp_addr <= haddr[7:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   sequence s_rd_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   sequence s_rd_at(logic [7:0] a);
      acc_rd && haddr[7:0] == a ##1 s_rd_answer;
   endsequence
   a_read_one_wait: assert property (acc_rd |=> s_rd_answer)
      else $error("read answer not after one wait state");
   a_prescale_rsvd: assert property (s_rd_at(8'h04) |-> hrdata[31:4] == 28'h0)
      else $error("reserved prescale bits not zero");
   a_trigger_reads_zero: assert property (s_rd_at(8'h00) |-> !hrdata[6])
      else $error("select trigger reads back set");
   a_active_follows: assert property ($changed(active_source) |->
      active_source == osc_enable_select)
      else $error("active source differs from selection");
   a_source_protected: assert property ($changed(osc_enable_select) && $past(hreadyout) |->
      $past(dp_wr) && $past(dp_addr) == 8'h00)
      else $error("selection changed without a write");
   a_fast_trim_write: assert property ($changed(fast_trim_value) && $past(hreadyout) |->
      $past(dp_wr) && $past(dp_addr) == 8'h08)
      else $error("fast trim changed without a write");
   a_temp_trim_write: assert property ($changed(fast_temp_trim_a) |->
      $past(dp_wr) && $past(dp_addr) == 8'h0C)
      else $error("temperature trim changed without a write");
   a_clkout_follow: assert property (!clk_out_oe_n && !$past(clk_out_oe_n) |->
      clk_out_pin == $past(sys_clk))
      else $error("clock output pin does not follow system clock");
   a_clkout_quiet: assert property (clk_out_oe_n |-> !clk_out_pin)
      else $error("clock output toggles while released");
endmodule
bind sys_clk_ctrl sys_clk_ctrl_props props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .osc_enable_select(osc_enable_select),
   .active_source(active_source), .fast_trim_value(fast_trim_value),
   .fast_temp_trim_a(fast_temp_trim_a), .sys_clk(sys_clk), .clk_out_pin(clk_out_pin),
   .clk_out_oe_n(clk_out_oe_n));
`default_nettype wire

/* tb/system_clock_select_prescale_bench.sv */
// Self-checking bench for the system clock control block.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
module system_clock_select_prescale_bench;
   import clk_ctrl_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, rd_dp, osc_ready;
   logic        fuse_sut, cko_fuse, div8_fuse, hreadyout, hresp, su_sel;
   logic        sys_tick, sys_clk, clk_out_pin, clk_out_oe_n;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rng;
   sel_t        fuse_src, osc_en, act_src;
   trim_t       ft, tta, ttb, st;
   int          failures, cmp_count;
   logic [31:0] expq[$];
   logic [3:0]  codes[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
                              4'h9, 4'hF};
   sys_clk_ctrl #(.STARTUP_CYCLES(20)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .fuse_source_select(fuse_src), .fuse_startup_time(fuse_sut), .clk_out_fuse(cko_fuse),
      .divide_by_eight_fuse(div8_fuse), .factory_fast_trim(8'h3C),
      .factory_slow_trim(8'hC3), .osc_ready(osc_ready), .osc_enable_select(osc_en),
      .active_source(act_src), .startup_time_sel(su_sel), .fast_trim_value(ft),
      .fast_temp_trim_a(tta), .fast_temp_trim_b(ttb), .slow_trim_value(st),
      .sys_tick(sys_tick), .sys_clk(sys_clk), .clk_out_pin(clk_out_pin),
      .clk_out_oe_n(clk_out_oe_n));
   initial hclk = 1'b0;
   always #2.5 hclk = ~hclk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // One single transfer; entered just after a rising edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(a, 1'b0, 32'h0);
   endtask
   task automatic prot(input logic [7:0] a, input logic [31:0] d);
      bus(8'h18, 1'b1, 32'hA5);
      bus(a, 1'b1, d);
   endtask
   // Skips three ticks, past the period in which the new setting lands, then times one period
   task automatic meas(input int f);
      int n;
      repeat (3)
      begin
         do @(posedge hclk); while (sys_tick !== 1'b1);
      end
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (sys_tick !== 1'b1);
      check(32'(n), 32'(f));
   endtask
   task automatic do_reset();
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Read answers are compared in the cycle hreadyout closes the data phase
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rd_dp <= 1'b0;
      else
      begin
         if (rd_dp && hreadyout === 1'b1)
            check(hrdata, expq.pop_front());
         if (hreadyout === 1'b1)
            rd_dp <= hsel && htrans[1] && !hwrite;
      end
   end
   initial
   begin
      repeat (60000) @(posedge hclk);
      failures++;
      wrap_up();
   end
   initial
   begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      {fuse_src, fuse_sut, cko_fuse, div8_fuse, osc_ready} = {4'h6, 4'b1110};
      rng = 32'h5EF1;
      do_reset();
      rd(8'h00, 32'h36);
      rd(8'h04, 32'h03);
      rd(8'h08, 32'h3C);
      rd(8'h0C, 32'h80);
      rd(8'h14, 32'hC3);
      rd(8'h1C, 32'h00);
      check({31'h0, clk_out_oe_n}, 32'h0);
      bus(8'h04, 1'b1, 32'h01);
      check({31'h0, hresp}, 32'h0);
      rd(8'h04, 32'h03);
      bus(8'h18, 1'b1, 32'hA5);
      rd(8'h18, 32'h01);
      bus(8'h04, 1'b1, 32'h03);
      rd(8'h18, 32'h00);
      foreach (codes[i])
      begin
         prot(8'h04, {28'hF, codes[i]});
         rd(8'h04, {28'h0, codes[i]});
         meas(codes[i] > 4'h8 ? 256 : 1 << codes[i]);
      end
      prot(8'h04, 32'h00);
      // Let the slow period run out so the window below counts single cycles
      meas(1);
      // Window lasts four ticks; at factor one that is four cycles
      bus(8'h18, 1'b1, 32'hA5);
      repeat (8) @(posedge hclk);
      bus(8'h04, 1'b1, 32'h05);
      rd(8'h04, 32'h00);
      osc_ready <= 1'b1;
      prot(8'h00, 32'h34);
      @(posedge hclk);
      check({osc_en, act_src}, 8'h46);
      repeat (40) @(posedge hclk);
      rd(8'h00, 32'hB4);
      prot(8'h00, 32'h72);
      @(posedge hclk);
      check({osc_en, act_src}, 8'h22);
      rd(8'h00, 32'h32);
      repeat (40) @(posedge hclk);
      bus(8'h00, 1'b1, 32'hC5);
      rd(8'h00, 32'h82);
      check({clk_out_oe_n, clk_out_pin}, 32'h2);
      for (int a = 8; a <= 20; a += 4)
      begin
         rng = xs(rng);
         // Fast trim stays within a small step of its factory value
         if (a == 8)
            rng[7:0] = 8'h3C + {3'h0, rng[4:0]};
         bus(8'(a), 1'b1, {24'h0, rng[7:0]});
         rd(8'(a), {24'h0, rng[7:0]});
         check(a == 8 ? ft : a == 12 ? tta : a == 16 ? ttb : st, rng[7:0]);
      end
      {fuse_src, fuse_sut, cko_fuse, div8_fuse} <= 7'h00;
      do_reset();
      rd(8'h04, 32'h00);
      rd(8'h00, 32'h00);
      rd(8'h08, 32'h3C);
      check({su_sel, clk_out_oe_n}, 32'h1);
      wrap_up();
   end
endmodule
`default_nettype wire
